// [logic/chp_pkg.sv]
// constants and types shared by the card host-port pin logic
// Summary of operation
// - card-bus modes decode address with attribute select
// - ide mode: low three bits pick register
// - memory mode: first battery status high
// - memory mode: second battery status high
// - io mode: status-changed low on ready/protect change
// - no audio: audio output held negated
// - ide pass-diagnostic is bidirectional handshake
// - ide activity line signals activity, slave presence
// - both card-detect outputs always ground
// - ide role: grounded master, open slave
package chp_pkg;
  typedef enum logic [2:0] {
    CHP_MODE_MEM = 3'b001,
    CHP_MODE_IO  = 3'b010,
    CHP_MODE_IDE = 3'b100
  } chp_mode_t;

  typedef enum logic [3:0] {
    CHP_SEL_IO_PORT  = 4'b0001,
    CHP_SEL_MEM_PORT = 4'b0010,
    CHP_SEL_INFO     = 4'b0100,
    CHP_SEL_CONFIG   = 4'b1000
  } chp_sel_t;

  localparam int        CHP_ADDR_W      = 11;
  localparam int        CHP_TASK_W      = 3;
  localparam int        CHP_SYNC_STAGES = 3;
  // attribute space: address bit 9 clear selects info structure, bit 9 set selects config registers
  localparam int        CHP_CFG_BIT     = 9;
  // hold count for the diagnostic-passed indication, in cycles; no logic reads it, so the indication is not stretched
  localparam logic [7:0] CHP_DIAG_HOLD  = 8'h10;
  localparam logic       CHP_STRAP_RST  = 1'b0;
endpackage

// [logic/chp_sync.sv]
// three-stage synchroniser with agreement filter for a group of pin inputs
module chp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  input  wire logic [WIDTH-1:0] reset_val_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] filt;
  logic [WIDTH-1:0] next_filt;
  logic [WIDTH-1:0] agree_filt;
  logic [1:0]       prime_cnt;
  logic [1:0]       next_prime_cnt;

  localparam logic [1:0] PRIMED = 2'(chp_pkg::CHP_SYNC_STAGES);

  // stage1 is only read by stage2; a change counts when stage2 and stage3 agree
  genvar g;
  for (g = 0; g < WIDTH; g++) begin : g_bit
    always_comb begin
      agree_filt[g] = (stage2[g] == stage3[g]) ? stage3[g] : filt[g];
    end
  end

  always_comb begin
    next_prime_cnt = (prime_cnt == PRIMED) ? prime_cnt : prime_cnt + 2'h1;
    // the stages reset to zero, not to the pin's idle level; show the idle value until real samples fill them
    next_filt      = (prime_cnt == PRIMED) ? agree_filt : reset_val_i;
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stage1    <= '0;
      stage2    <= '0;
      stage3    <= '0;
      filt      <= '0;
      prime_cnt <= 2'h0;
    end else begin
      stage1    <= async_i;
      stage2    <= stage1;
      stage3    <= stage2;
      prime_cnt <= next_prime_cnt;
      filt      <= next_filt;
    end
  end

  assign sync_o = filt;
endmodule

// [logic/chp_pins.sv]
// host-port pin logic: address decode, status pins, master/slave handshake
module chp_pins (
  input  wire logic                              sys_clk_i,
  input  wire logic                              reset_n_i,
  input  wire chp_pkg::chp_mode_t                mode_i,
  input  wire logic [chp_pkg::CHP_ADDR_W-1:0]    addr_i,
  input  wire logic                              attr_sel_n_i,
  input  wire logic                              io_cycle_i,
  input  wire logic                              ready_i,
  input  wire logic                              write_protect_i,
  input  wire logic                              status_change_en_i,
  input  wire logic                              role_select_n_i,
  input  wire logic                              diag_passed_i,
  input  wire logic                              disk_active_i,
  input  wire logic                              pass_diagnostic_n_i,
  input  wire logic                              active_slave_present_n_i,
  output logic [3:0]                             space_sel_o,
  output logic [chp_pkg::CHP_TASK_W-1:0]         task_reg_o,
  output logic [chp_pkg::CHP_ADDR_W-1:0]         reg_offset_o,
  output logic                                   upper_addr_err_o,
  output logic                                   battery_status_one_o,
  output logic                                   battery_status_two_o,
  output logic                                   status_changed_n_o,
  output logic                                   audio_out_n_o,
  output logic                                   pass_diagnostic_n_o,
  output logic                                   pass_diagnostic_n_oe_o,
  output logic                                   active_slave_present_n_o,
  output logic                                   active_slave_present_n_oe_o,
  output logic                                   card_detect_one_n_o,
  output logic                                   card_detect_two_n_o,
  output logic                                   is_master_o,
  output logic                                   peer_diag_passed_o,
  output logic                                   slave_present_o
);
  localparam int AW = chp_pkg::CHP_ADDR_W;
  localparam int TW = chp_pkg::CHP_TASK_W;

  // pins from the host side cross into sys_clk through the filter
  logic [2:0] pin_raw;
  logic [2:0] pin_sync;
  logic [2:0] pin_idle;
  assign pin_raw  = {role_select_n_i, pass_diagnostic_n_i, active_slave_present_n_i};
  assign pin_idle = 3'b111;

  chp_sync #(
    .WIDTH(3)
  ) u_sync (
    .sys_clk_i  (sys_clk_i),
    .reset_n_i  (reset_n_i),
    .async_i    (pin_raw),
    .reset_val_i(pin_idle),
    .sync_o     (pin_sync)
  );

  logic role_n_s;
  logic pass_diagnostic_n_n_s;
  logic active_slave_present_n_n_s;
  assign role_n_s  = pin_sync[2];
  assign pass_diagnostic_n_n_s = pin_sync[1];
  assign active_slave_present_n_n_s  = pin_sync[0];

  logic is_ide;
  logic is_mem;
  logic is_io;
  assign is_ide = (mode_i == chp_pkg::CHP_MODE_IDE);
  assign is_mem = (mode_i == chp_pkg::CHP_MODE_MEM);
  assign is_io  = (mode_i == chp_pkg::CHP_MODE_IO);

  // address decode group
  logic [3:0]    space_sel;
  logic [3:0]    next_space_sel;
  logic [TW-1:0] task_reg;
  logic [TW-1:0] next_task_reg;
  logic [AW-1:0] reg_offset;
  logic [AW-1:0] next_reg_offset;
  logic          upper_err;
  logic          next_upper_err;

  always_comb begin
    next_space_sel  = 4'h0;
    next_task_reg   = task_reg;
    next_reg_offset = reg_offset;
    next_upper_err  = 1'b0;
    if (is_ide) begin
      next_task_reg  = addr_i[TW-1:0];
      next_upper_err = |addr_i[AW-1:TW];
    end else begin
      next_reg_offset = addr_i;
      if (!attr_sel_n_i) begin
        next_space_sel = addr_i[chp_pkg::CHP_CFG_BIT] ? chp_pkg::CHP_SEL_CONFIG : chp_pkg::CHP_SEL_INFO;
      end else if (io_cycle_i) begin
        next_space_sel = chp_pkg::CHP_SEL_IO_PORT;
      end else begin
        next_space_sel = chp_pkg::CHP_SEL_MEM_PORT;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      space_sel  <= 4'h0;
      task_reg   <= '0;
      reg_offset <= '0;
      upper_err  <= 1'b0;
    end else begin
      space_sel  <= next_space_sel;
      task_reg   <= next_task_reg;
      reg_offset <= next_reg_offset;
      upper_err  <= next_upper_err;
    end
  end

  // status pin group
  logic battery_status_one;
  logic next_battery_status_one;
  logic battery_status_two;
  logic next_battery_status_two;
  logic status_changed_n_n;
  logic next_status_changed_n_n;
  logic audio_out_n_n;
  logic next_audio_out_n_n;
  logic ready_q;
  logic wp_q;
  logic cd_n;

  always_comb begin
    next_battery_status_one     = 1'b1;
    next_battery_status_two     = 1'b1;
    next_audio_out_n_n   = 1'b1;
    next_status_changed_n_n = 1'b1;
    if (is_io && status_change_en_i && ((ready_i != ready_q) || (write_protect_i != wp_q))) begin
      next_status_changed_n_n = 1'b0;
    end
    if (is_io) begin
      next_battery_status_one = next_status_changed_n_n;
    end else if (is_ide) begin
      next_battery_status_one = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      battery_status_one     <= 1'b1;
      battery_status_two     <= 1'b1;
      status_changed_n_n <= 1'b1;
      audio_out_n_n   <= 1'b1;
      ready_q  <= 1'b0;
      wp_q     <= 1'b0;
      cd_n     <= 1'b0;
    end else begin
      battery_status_one     <= next_battery_status_one;
      battery_status_two     <= next_battery_status_two;
      status_changed_n_n <= next_status_changed_n_n;
      audio_out_n_n   <= next_audio_out_n_n;
      ready_q  <= ready_i;
      wp_q     <= write_protect_i;
      cd_n     <= 1'b0;
    end
  end

  // master/slave handshake group
  // strap and peer lines are believed only once the filter shows real pin levels
  localparam logic [2:0] SETTLE = 3'(chp_pkg::CHP_SYNC_STAGES + 1);
  logic       master;
  logic       next_master;
  logic       role_taken;
  logic       next_role_taken;
  logic [2:0] role_wait;
  logic [2:0] next_role_wait;
  logic [2:0] pd_quiet;
  logic [2:0] next_pd_quiet;
  logic [2:0] active_slave_present_n_quiet;
  logic [2:0] next_active_slave_present_n_quiet;
  logic pd_oe;
  logic next_pd_oe;
  logic active_slave_present_n_oe;
  logic next_active_slave_present_n_oe;
  logic peer_pass;
  logic next_peer_pass;
  logic slave_seen;
  logic next_slave_seen;

  always_comb begin
    next_master     = master;
    next_role_taken = role_taken;
    next_role_wait  = (role_wait == SETTLE) ? role_wait : role_wait + 3'h1;
    if (!role_taken && (role_wait == SETTLE)) begin
      next_master     = !role_n_s;
      next_role_taken = 1'b1;
    end
    // own pull-down echoes back late through the filter; a peer pulling meanwhile is missed
    next_pd_quiet   = pd_oe ? 3'h0 : ((pd_quiet == SETTLE) ? pd_quiet : pd_quiet + 3'h1);
    next_active_slave_present_n_quiet = active_slave_present_n_oe ? 3'h0 : ((active_slave_present_n_quiet == SETTLE) ? active_slave_present_n_quiet : active_slave_present_n_quiet + 3'h1);
    // open-drain: drive low only, so the enable is the asserted level
    next_pd_oe = 1'b0;
    next_active_slave_present_n_oe = 1'b0;
    next_peer_pass = 1'b0;
    next_slave_seen = 1'b0;
    if (is_ide) begin
      next_pd_oe     = !master && diag_passed_i;
      next_peer_pass = master && !pass_diagnostic_n_n_s && (pd_quiet == SETTLE);
      // activity from either, presence from slave
      next_active_slave_present_n_oe    = disk_active_i || (!master && !diag_passed_i);
      next_slave_seen = master && !active_slave_present_n_n_s && (active_slave_present_n_quiet == SETTLE);
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      master     <= chp_pkg::CHP_STRAP_RST;
      role_taken <= 1'b0;
      role_wait  <= 3'h0;
      pd_quiet   <= 3'h0;
      active_slave_present_n_quiet <= 3'h0;
      pd_oe      <= 1'b0;
      active_slave_present_n_oe    <= 1'b0;
      peer_pass  <= 1'b0;
      slave_seen <= 1'b0;
    end else begin
      master     <= next_master;
      role_taken <= next_role_taken;
      role_wait  <= next_role_wait;
      pd_quiet   <= next_pd_quiet;
      active_slave_present_n_quiet <= next_active_slave_present_n_quiet;
      pd_oe      <= next_pd_oe;
      active_slave_present_n_oe    <= next_active_slave_present_n_oe;
      peer_pass  <= next_peer_pass;
      slave_seen <= next_slave_seen;
    end
  end

  assign space_sel_o                 = space_sel;
  assign task_reg_o                  = task_reg;
  assign reg_offset_o                = reg_offset;
  assign upper_addr_err_o            = upper_err;
  assign battery_status_one_o        = battery_status_one;
  assign battery_status_two_o        = battery_status_two;
  assign status_changed_n_o          = status_changed_n_n;
  assign audio_out_n_o               = audio_out_n_n;
  assign pass_diagnostic_n_o         = 1'b0;
  assign pass_diagnostic_n_oe_o      = pd_oe;
  assign active_slave_present_n_o    = 1'b0;
  assign active_slave_present_n_oe_o = active_slave_present_n_oe;
  assign card_detect_one_n_o         = cd_n;
  assign card_detect_two_n_o         = cd_n;
  assign is_master_o                 = master;
  assign peer_diag_passed_o          = peer_pass;
  assign slave_present_o             = slave_seen;
endmodule

// [bench/chp_host_model.sv]
// host socket and peer device model facing the card pins
module chp_host_model (
  input  wire logic                           ide_i,
  input  wire logic [chp_pkg::CHP_ADDR_W-1:0] want_addr_i,
  input  wire logic                           card_detect_one_n_i,
  input  wire logic                           card_detect_two_n_i,
  input  wire logic                           dut_pass_diagnostic_n_oe_i,
  input  wire logic                           dut_active_slave_present_n_oe_i,
  input  wire logic                           peer_pass_diagnostic_n_i,
  input  wire logic                           peer_active_slave_present_n_i,
  output logic      [chp_pkg::CHP_ADDR_W-1:0] addr_o,
  output logic                                card_in_o,
  output logic                                pass_diagnostic_n_wire_o,
  output logic                                active_slave_present_n_wire_o
);
  timeunit 1ns;
  timeprecision 1ps;
  assign addr_o = ide_i ? {8'h00, want_addr_i[2:0]} : want_addr_i;
  assign card_in_o = !card_detect_one_n_i && !card_detect_two_n_i;
  // pulled-up lines, any party may pull low
  assign pass_diagnostic_n_wire_o = !(dut_pass_diagnostic_n_oe_i || peer_pass_diagnostic_n_i);
  assign active_slave_present_n_wire_o = !(dut_active_slave_present_n_oe_i || peer_active_slave_present_n_i);
endmodule

// [bench/chp_pins_chk.sv]
// assertion checker for the card host-port pin logic
module chp_pins_chk (
  input wire logic                           sys_clk_i,
  input wire logic                           reset_n_i,
  input wire chp_pkg::chp_mode_t             mode_i,
  input wire logic [chp_pkg::CHP_ADDR_W-1:0] addr_i,
  input wire logic                           attr_sel_n_i,
  input wire logic                           io_cycle_i,
  input wire logic                           ready_i,
  input wire logic                           write_protect_i,
  input wire logic                           status_change_en_i,
  input wire logic [3:0]                     space_sel_o,
  input wire logic [chp_pkg::CHP_TASK_W-1:0] task_reg_o,
  input wire logic                           battery_status_one_o,
  input wire logic                           battery_status_two_o,
  input wire logic                           status_changed_n_o,
  input wire logic                           audio_out_n_o,
  input wire logic                           card_detect_one_n_o,
  input wire logic                           card_detect_two_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  logic cbus;
  logic io_alert;
  assign cbus = (mode_i == chp_pkg::CHP_MODE_MEM) || (mode_i == chp_pkg::CHP_MODE_IO);
  assign io_alert = (mode_i == chp_pkg::CHP_MODE_IO) && status_change_en_i;
  chk_detect_ground: assert property (!card_detect_one_n_o && !card_detect_two_n_o)
    else $error("card detect not grounded");
  chk_bat_one_mem: assert property (mode_i == chp_pkg::CHP_MODE_MEM |=> battery_status_one_o)
    else $error("first battery status low in memory mode");
  chk_bat_two_mem: assert property (mode_i == chp_pkg::CHP_MODE_MEM |=> battery_status_two_o)
    else $error("second battery status low in memory mode");
  chk_audio_negated: assert property (mode_i == chp_pkg::CHP_MODE_IO |=> audio_out_n_o)
    else $error("audio output asserted");
  chk_task_index: assert property (mode_i == chp_pkg::CHP_MODE_IDE |=>
    task_reg_o == $past(addr_i[2:0]) && space_sel_o == 4'h0) else $error("task register index wrong");
  chk_attr_space: assert property (cbus && !attr_sel_n_i |=>
    space_sel_o == ($past(addr_i[chp_pkg::CHP_CFG_BIT]) ? 4'h8 : 4'h4)) else $error("attribute decode wrong");
  chk_port_space: assert property (cbus && attr_sel_n_i |=>
    space_sel_o == ($past(io_cycle_i) ? 4'h1 : 4'h2)) else $error("port decode wrong");
  chk_alert_pulse: assert property (io_alert && ($changed(ready_i) || $changed(write_protect_i))
    |=> !status_changed_n_o) else $error("status change not alerted");
  chk_alert_off: assert property (!status_change_en_i |=> status_changed_n_o)
    else $error("alert while disabled");
  cover property (io_alert && $changed(ready_i) ##1 !status_changed_n_o);
  cover property (cbus && !attr_sel_n_i && addr_i[chp_pkg::CHP_CFG_BIT]);
  cover property (mode_i == chp_pkg::CHP_MODE_IDE ##1 task_reg_o == 3'h7);
endmodule

bind chp_pins chp_pins_chk u_chp_pins_chk (.sys_clk_i, .reset_n_i, .mode_i, .addr_i, .attr_sel_n_i,
  .io_cycle_i, .ready_i, .write_protect_i, .status_change_en_i, .space_sel_o, .task_reg_o,
  .battery_status_one_o, .battery_status_two_o, .status_changed_n_o, .audio_out_n_o,
  .card_detect_one_n_o, .card_detect_two_n_o);

// [bench/tb_chp_pins.sv]
// self-checking bench for the card host-port pin logic
module tb_chp_pins;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk = 1'b0, rst_n = 1'b0, attr_n = 1'b1, io_cyc = 1'b0, rdy = 1'b0, wp = 1'b0;
  logic               en = 1'b0, role_n = 1'b1, diag = 1'b0, act = 1'b0, peer_pd = 1'b0, peer_da = 1'b0;
  chp_pkg::chp_mode_t mode = chp_pkg::CHP_MODE_MEM;
  logic [10:0]        want = 11'h000, addr, offset;
  logic [3:0]         sel;
  logic [2:0]         treg;
  logic               uerr, bat1, bat2, stc_n, aud_n, pd_o, pd_oe, da_o, da_oe, cd1_n, cd2_n;
  logic               master, peer_ok, slave_in, card_in, pd_w, da_w;
  int                 errors = 0, n_tests = 0;
  initial forever #2 clk = ~clk;
  chp_host_model u_chp_host_model (.ide_i(mode == chp_pkg::CHP_MODE_IDE), .want_addr_i(want),
    .card_detect_one_n_i(cd1_n), .card_detect_two_n_i(cd2_n), .dut_pass_diagnostic_n_oe_i(pd_oe), .dut_active_slave_present_n_oe_i(da_oe),
    .peer_pass_diagnostic_n_i(peer_pd), .peer_active_slave_present_n_i(peer_da), .addr_o(addr), .card_in_o(card_in),
    .pass_diagnostic_n_wire_o(pd_w), .active_slave_present_n_wire_o(da_w));
  chp_pins u_chp_pins (.sys_clk_i(clk), .reset_n_i(rst_n), .mode_i(mode), .addr_i(addr), .attr_sel_n_i(attr_n),
    .io_cycle_i(io_cyc), .ready_i(rdy), .write_protect_i(wp), .status_change_en_i(en), .role_select_n_i(role_n),
    .diag_passed_i(diag), .disk_active_i(act), .pass_diagnostic_n_i(pd_w), .active_slave_present_n_i(da_w),
    .space_sel_o(sel), .task_reg_o(treg), .reg_offset_o(offset), .upper_addr_err_o(uerr),
    .battery_status_one_o(bat1), .battery_status_two_o(bat2), .status_changed_n_o(stc_n),
    .audio_out_n_o(aud_n), .pass_diagnostic_n_o(pd_o), .pass_diagnostic_n_oe_o(pd_oe),
    .active_slave_present_n_o(da_o), .active_slave_present_n_oe_o(da_oe), .card_detect_one_n_o(cd1_n),
    .card_detect_two_n_o(cd2_n), .is_master_o(master), .peer_diag_passed_o(peer_ok), .slave_present_o(slave_in));
  task automatic summarize();
    if (errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      errors++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask
  // bounded wait; a timeout ends the run
  task automatic wait_hi(input int s, input string msg);
    logic v;
    v = 1'b0;
    for (int i = 0; i < 20 && v !== 1'b1; i++) begin
      @(posedge clk);
      #1;
      v = (s == 0) ? master : (s == 1) ? peer_ok : (s == 2) ? slave_in : (s == 3) ? da_oe : pd_oe;
    end
    chk(v, msg);
    if (v !== 1'b1) summarize();
  endtask
  task automatic t_fixed_levels();
    chp_pkg::chp_mode_t m[3] = '{chp_pkg::CHP_MODE_MEM, chp_pkg::CHP_MODE_IO, chp_pkg::CHP_MODE_IDE};
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      mode <= m[i];
      repeat (2) @(posedge clk);
      #1;
      chk(cd1_n === 1'b0 && cd2_n === 1'b0 && card_in === 1'b1, "card detect level");
      chk(bat2 === 1'b1 && aud_n === 1'b1, "fixed status levels");
      if (i == 0) chk(bat1 === 1'b1, "first battery status");
    end
  endtask
  task automatic t_cardbus_decode();
    logic [3:0] exp;
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      mode <= k[2] ? chp_pkg::CHP_MODE_IO : chp_pkg::CHP_MODE_MEM;
      attr_n <= k[1];
      io_cyc <= k[0];
      want <= k[0] ? 11'h7ff : 11'h1ff;
      exp = !k[1] ? (k[0] ? 4'h8 : 4'h4) : (k[0] ? 4'h1 : 4'h2);
      @(posedge clk);
      #1;
      chk(sel === exp && offset === (k[0] ? 11'h7ff : 11'h1ff), "card-bus decode");
    end
  endtask
  task automatic t_ide_decode();
    for (int a = 0; a < 8; a++) begin
      @(posedge clk);
      mode <= chp_pkg::CHP_MODE_IDE;
      want <= 11'h7f8 | 11'(a);
      @(posedge clk);
      #1;
      chk(treg === 3'(a) && sel === 4'h0 && uerr === 1'b0, "task register select");
    end
  endtask
  // enable 1: one short low pulse; enable 0: none
  task automatic t_status_alert(input logic on, input logic flip_wp);
    int lows;
    int lows1;
    lows = 0;
    lows1 = 0;
    @(posedge clk);
    mode <= chp_pkg::CHP_MODE_IO;
    en <= on;
    repeat (3) @(posedge clk);
    if (flip_wp) wp <= ~wp;
    else rdy <= ~rdy;
    repeat (4) begin
      @(posedge clk);
      #1;
      lows += (stc_n === 1'b0);
      lows1 += (bat1 === 1'b0);
    end
    chk(lows == (on ? 1 : 0) && stc_n === 1'b1, "status-changed pulse");
    chk(lows1 == (on ? 1 : 0) && bat1 === 1'b1, "shared status pin pulse");
  endtask
  task automatic t_role_handshake();
    @(posedge clk);
    mode <= chp_pkg::CHP_MODE_IDE;
    diag <= 1'b1;
    wait_hi(4, "slave reports diagnostic pass");
    chk(master === 1'b0 && pd_o === 1'b0 && da_o === 1'b0, "open strap gives slave");
    @(posedge clk);
    rst_n <= 1'b0;
    role_n <= 1'b0;
    diag <= 1'b0;
    mode <= chp_pkg::CHP_MODE_IDE;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    wait_hi(0, "grounded strap gives master");
    @(posedge clk);
    peer_pd <= 1'b1;
    wait_hi(1, "peer diagnostic seen");
    @(posedge clk);
    peer_da <= 1'b1;
    wait_hi(2, "slave presence seen");
    @(posedge clk);
    act <= 1'b1;
    wait_hi(3, "activity drives line");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_fixed_levels();
    t_cardbus_decode();
    t_ide_decode();
    t_status_alert(1'b1, 1'b0);
    t_status_alert(1'b1, 1'b1);
    t_status_alert(1'b0, 1'b0);
    t_role_handshake();
    summarize();
  end
endmodule
